// file: pkg/addr_mode_pkg.sv
// Shared types and constants for the operand address-mode unit
package addr_mode_pkg;

  // Addressing modes presented by the opcode decoder
  typedef enum logic [3:0] {
    MODE_INH,
    MODE_IMM,
    MODE_DIR_S,
    MODE_DIR_L,
    MODE_IDX_0,
    MODE_IDX_S,
    MODE_IDX_L,
    MODE_IND_S,
    MODE_IND_L,
    MODE_IIX_S,
    MODE_IIX_L,
    MODE_REL_D,
    MODE_REL_I
  } mode_type;

  // One decode request, taken when start_i is high in idle
  typedef struct packed {
    mode_type   mode;
    logic       use_y;
    logic       rmw;
    logic       set_irq_mask_op;
    logic       clear_irq_mask_op;
  } req_type;

  // Result held from done_o until the next request is taken
  typedef struct packed {
    logic [15:0] ea;
    logic [7:0]  operand;
    logic [1:0]  length;
    logic        has_ea;
    logic        refused;
  } res_type;

  localparam logic [7:0]  PAGE_ZERO_HI  = 8'h00;
  localparam logic [15:0] PAGE_ZERO_END = 16'h00FF;
  localparam logic [15:0] ADDR_STEP     = 16'h0001;
  localparam logic [7:0]  PTR_STEP      = 8'h01;
  localparam logic [1:0]  IRQ_LEVEL_MAX = 2'h3;
  localparam logic [1:0]  IRQ_LEVEL_MIN = 2'h0;
  localparam logic [1:0]  IRQ_LEVEL_RST = 2'h3;
  localparam logic [1:0]  LEN_ONE       = 2'h1;
  localparam logic [1:0]  LEN_TWO       = 2'h2;
  localparam logic [1:0]  LEN_THREE     = 2'h3;

endpackage

// file: hw/ea_adder.sv
// Effective-address adder: unsigned index add or signed relative add
`timescale 1ns/100ps
`default_nettype none
module ea_adder (
  input  wire logic [15:0] base_i,
  input  wire logic [7:0]  offset_i,
  input  wire logic        signed_i,
  output logic      [15:0] sum_o
);
  logic [15:0] ext;

  // (RL19) Index carry kept as bit 8; a carry out of bit 15 is dropped
  always_comb begin
    ext   = signed_i ? {{8{offset_i[7]}}, offset_i} : {8'h00, offset_i};
    sum_o = base_i + ext;
  end
endmodule
`default_nettype wire

// file: hw/addr_mode_unit.sv
// Operand address-mode unit: fetches operand bytes and forms the address
//
// Overview of operation
// (RL1) Inherent ops are one byte; nothing is fetched beyond the opcode.
// (RL2) Immediate ops are two bytes; the byte after the opcode is the operand.
// (RL3) Short variants stay in page zero, short indexed ones reach 1FE; long variants reach all 64K.
// (RL4) Read-modify-write ops accept short variants only; long ones refused.
// (RL5) Short direct: one byte after opcode is the address, 00 to FF.
// (RL6) Long direct: two bytes after opcode form a 16-bit address.
// (RL7) Indexed: address is unsigned sum of X or Y and the offset.
// (RL8) Indexed no offset: index alone is the address, no byte fetched.
// (RL9) Short indexed: byte offset plus index, reaching 00 to 1FE.
// (RL10) Long indexed: word offset plus index, reaching all 64K.
// (RL11) Indirect: byte after opcode addresses a pointer read from memory.
// (RL12) Short indirect: byte pointer address, byte pointer, 00 to FF.
// (RL13) Long indirect forms read a word pointer from a page-zero address.
// (RL14) Indirect indexed: pointer read from memory plus index register.
// (RL15) Short indirect indexed: byte pointer plus index, 00 to 1FE.
// (RL16) Set-mask op raises the interrupt mask to level 3.
// (RL17) Clear-mask op lowers the interrupt mask to level 0; if set-mask is also requested, the unit sets level 3.
// (RL18) Relative: signed 8-bit offset, direct or read from memory, moves PC.
// (RL19) Byte fields are zero-extended except the signed relative offset; index carry kept as address bit 8.
`timescale 1ns/100ps
`default_nettype none
module addr_mode_unit (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    start_i,
  input  wire addr_mode_pkg::req_type  req_i,
  input  wire logic [15:0]             pc_i,
  input  wire logic [7:0]              x_i,
  input  wire logic [7:0]              y_i,
  output logic                         busy_o,
  output logic                         mem_rd_o,
  output logic [15:0]                  mem_addr_o,
  input  wire logic [7:0]              mem_rdata_i,
  input  wire logic                    mem_ack_i,
  output logic                         done_o,
  output addr_mode_pkg::res_type       res_o,
  output logic [1:0]                   irq_level_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH1,
    ST_FETCH2,
    ST_PTR1,
    ST_PTR2
  } state_type;

  state_type              state_ff, nxt_state;
  addr_mode_pkg::req_type req_ff, nxt_req;
  addr_mode_pkg::res_type res_ff, nxt_res;
  logic [15:0]            pc_ff, nxt_pc;
  logic [7:0]             ptr_ff, nxt_ptr;
  logic [7:0]             hi_ff, nxt_hi;
  logic                   rd_ff, nxt_rd;
  logic [15:0]            maddr_ff, nxt_maddr;
  logic                   done_ff, nxt_done;
  logic [1:0]             irq_ff, nxt_irq;

  logic [15:0]            add_base;
  logic [7:0]             add_off;
  logic                   add_signed;
  logic [15:0]            add_sum;
  logic [7:0]             index;
  logic [15:0]            pc_next2;
  // (RL3) Page-zero extension
  function automatic logic [15:0] zext(input logic [7:0] b);
    zext = {addr_mode_pkg::PAGE_ZERO_HI, b};
  endfunction
  function automatic logic is_long(input addr_mode_pkg::mode_type m);
    is_long = (m == addr_mode_pkg::MODE_DIR_L) ||
              (m == addr_mode_pkg::MODE_IDX_L) ||
              (m == addr_mode_pkg::MODE_IND_L) ||
              (m == addr_mode_pkg::MODE_IIX_L);
  endfunction
  function automatic logic is_rel(input addr_mode_pkg::mode_type m);
    is_rel = (m == addr_mode_pkg::MODE_REL_D) ||
             (m == addr_mode_pkg::MODE_REL_I);
  endfunction
  assign index    = req_ff.use_y ? y_i : x_i;
  assign pc_next2 = pc_ff + addr_mode_pkg::ADDR_STEP;
  // (RL7) Adder operand select
  always_comb begin
    add_signed = is_rel(req_ff.mode);
    add_off    = add_signed ? mem_rdata_i : index;
    if (add_signed) begin
      add_base = pc_next2;
    end else if (state_ff == ST_FETCH2) begin
      add_base = {ptr_ff, mem_rdata_i};
    end else if (state_ff == ST_PTR2) begin
      add_base = {hi_ff, mem_rdata_i};
    end else begin
      add_base = zext(mem_rdata_i);
    end
  end
  ea_adder u_adder (
    .base_i   (add_base),
    .offset_i (add_off),
    .signed_i (add_signed),
    .sum_o    (add_sum)
  );
  always_comb begin
    nxt_state = state_ff;
    nxt_req   = req_ff;
    nxt_res   = res_ff;
    nxt_pc    = pc_ff;
    nxt_ptr   = ptr_ff;
    nxt_hi    = hi_ff;
    nxt_rd    = rd_ff;
    nxt_maddr = maddr_ff;
    nxt_done  = 1'b0;
    nxt_irq   = irq_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_i) begin
          nxt_req         = req_i;
          nxt_pc          = pc_i + addr_mode_pkg::ADDR_STEP;
          nxt_res         = '0;
          nxt_res.length  = addr_mode_pkg::LEN_TWO;
          nxt_maddr       = pc_i + addr_mode_pkg::ADDR_STEP;
          if (req_i.rmw && is_long(req_i.mode)) begin
            // (RL4) Long refused for rmw
            nxt_res.refused = 1'b1;
            nxt_done        = 1'b1;
          end else if (req_i.mode == addr_mode_pkg::MODE_INH) begin
            // (RL1) Single byte, no fetch
            nxt_res.length = addr_mode_pkg::LEN_ONE;
            nxt_done       = 1'b1;
            // (RL16) Mask to top level
            if (req_i.set_irq_mask_op) begin
              nxt_irq = addr_mode_pkg::IRQ_LEVEL_MAX;
            // (RL17) Mask to level zero
            end else if (req_i.clear_irq_mask_op) begin
              nxt_irq = addr_mode_pkg::IRQ_LEVEL_MIN;
            end
          end else if (req_i.mode == addr_mode_pkg::MODE_IDX_0) begin
            // (RL8) Index alone, no fetch
            nxt_res.length = addr_mode_pkg::LEN_ONE;
            nxt_res.ea     = zext(req_i.use_y ? y_i : x_i);
            nxt_res.has_ea = 1'b1;
            nxt_done       = 1'b1;
          end else begin
            nxt_rd    = 1'b1;
            nxt_state = ST_FETCH1;
          end
        end
      end
      ST_FETCH1: begin
        if (mem_ack_i) begin
          nxt_ptr        = mem_rdata_i;
          nxt_res.has_ea = 1'b1;
          nxt_done       = 1'b1;
          nxt_rd         = 1'b0;
          nxt_state      = ST_IDLE;
          unique case (req_ff.mode)
            addr_mode_pkg::MODE_IMM: begin
              // (RL2) Operand is the next byte
              nxt_res.operand = mem_rdata_i;
              nxt_res.has_ea  = 1'b0;
            end
            addr_mode_pkg::MODE_DIR_S: begin
              // (RL5) Page-zero direct address
              nxt_res.ea = zext(mem_rdata_i);
            end
            addr_mode_pkg::MODE_IDX_S: begin
              // (RL9) Byte offset plus index
              nxt_res.ea = add_sum;
            end
            addr_mode_pkg::MODE_REL_D: begin
              // (RL18) Signed offset onto PC
              nxt_res.ea = add_sum;
            end
            addr_mode_pkg::MODE_DIR_L,
            addr_mode_pkg::MODE_IDX_L: begin
              nxt_done       = 1'b0;
              nxt_rd         = 1'b1;
              nxt_maddr      = pc_next2;
              nxt_res.length = addr_mode_pkg::LEN_THREE;
              nxt_state      = ST_FETCH2;
            end
            default: begin
              // (RL11) Pointer read from page zero
              nxt_done  = 1'b0;
              nxt_rd    = 1'b1;
              nxt_maddr = zext(mem_rdata_i);
              nxt_state = ST_PTR1;
            end
          endcase
        end
      end
      ST_FETCH2: begin
        if (mem_ack_i) begin
          nxt_rd    = 1'b0;
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
          // (RL6) Word address, high byte first
          // (RL10) Word offset plus index
          nxt_res.ea = (req_ff.mode == addr_mode_pkg::MODE_IDX_L) ?
                       add_sum : {ptr_ff, mem_rdata_i};
        end
      end
      ST_PTR1: begin
        if (mem_ack_i) begin
          nxt_hi = mem_rdata_i;
          if (is_long(req_ff.mode)) begin
            // (RL13) Second pointer byte
            nxt_maddr = zext(ptr_ff + addr_mode_pkg::PTR_STEP);
            nxt_state = ST_PTR2;
          end else begin
            nxt_rd    = 1'b0;
            nxt_done  = 1'b1;
            nxt_state = ST_IDLE;
            // (RL12) Byte pointer in page zero
            // (RL15) Byte pointer plus index
            // (RL18) Offset read from memory
            nxt_res.ea = (req_ff.mode == addr_mode_pkg::MODE_IND_S) ?
                         zext(mem_rdata_i) : add_sum;
          end
        end
      end
      ST_PTR2: begin
        if (mem_ack_i) begin
          nxt_rd    = 1'b0;
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
          // (RL14) Word pointer plus index
          nxt_res.ea = (req_ff.mode == addr_mode_pkg::MODE_IIX_L) ?
                       add_sum : {hi_ff, mem_rdata_i};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      req_ff   <= '0;
      res_ff   <= '0;
      pc_ff    <= '0;
      ptr_ff   <= '0;
      hi_ff    <= '0;
      rd_ff    <= 1'b0;
      maddr_ff <= '0;
      done_ff  <= 1'b0;
      irq_ff   <= addr_mode_pkg::IRQ_LEVEL_RST;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      res_ff   <= nxt_res;
      pc_ff    <= nxt_pc;
      ptr_ff   <= nxt_ptr;
      hi_ff    <= nxt_hi;
      rd_ff    <= nxt_rd;
      maddr_ff <= nxt_maddr;
      done_ff  <= nxt_done;
      irq_ff   <= nxt_irq;
    end
  end

  assign busy_o      = (state_ff != ST_IDLE);
  assign mem_rd_o    = rd_ff;
  assign mem_addr_o  = maddr_ff;
  assign done_o      = done_ff;
  assign res_o       = res_ff;
  assign irq_level_o = irq_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_inh_start;
    start_i && !busy_o && req_i.mode == addr_mode_pkg::MODE_INH;
  endsequence
  property p_inh_one_byte;
    s_inh_start |=> done_o && res_o.length == 2'h1 && !mem_rd_o;
  endproperty
  a_inh_one_byte: assert property (p_inh_one_byte) // (RL1)
    else $error("inherent op fetched or wrong length");
  property p_imm_operand;
    busy_o && req_ff.mode == addr_mode_pkg::MODE_IMM && mem_ack_i
    |=> done_o && res_o.operand == $past(mem_rdata_i) && res_o.length == 2'h2;
  endproperty
  a_imm_operand: assert property (p_imm_operand) // (RL2)
    else $error("immediate operand not taken from next byte");
  property p_short_page0;
    done_o && (req_ff.mode == addr_mode_pkg::MODE_DIR_S ||
               req_ff.mode == addr_mode_pkg::MODE_IND_S ||
               req_ff.mode == addr_mode_pkg::MODE_IDX_0)
    |-> res_o.ea <= addr_mode_pkg::PAGE_ZERO_END;
  endproperty
  a_short_page0: assert property (p_short_page0) // (RL3)
    else $error("short mode left page zero");
  property p_rmw_long_refused;
    start_i && !busy_o && req_i.rmw && is_long(req_i.mode)
    |=> done_o && res_o.refused && !mem_rd_o;
  endproperty
  a_rmw_long_refused: assert property (p_rmw_long_refused) // (RL4)
    else $error("long rmw op not refused");
  property p_idx0_index;
    start_i && !busy_o && req_i.mode == addr_mode_pkg::MODE_IDX_0 &&
    !req_i.use_y |=> done_o && res_o.ea == {8'h00, $past(x_i)};
  endproperty
  a_idx0_index: assert property (p_idx0_index) // (RL8)
    else $error("no-offset index address wrong");
  property p_short_idx_nine_bits;
    done_o && (req_ff.mode == addr_mode_pkg::MODE_IDX_S ||
               req_ff.mode == addr_mode_pkg::MODE_IIX_S)
    |-> res_o.ea[15:9] == 7'h00;
  endproperty
  a_short_idx_nine_bits: assert property (p_short_idx_nine_bits) // (RL19)
    else $error("short indexed sum exceeds nine bits");
  property p_ptr_fetch;
    state_ff == ST_FETCH1 && mem_ack_i &&
    req_ff.mode == addr_mode_pkg::MODE_IND_S
    |=> mem_rd_o && mem_addr_o == {8'h00, $past(mem_rdata_i)};
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch) // (RL11)
    else $error("pointer not read at byte after opcode");
  // Second pointer byte must wrap inside page zero
  property p_long_ptr_word;
    state_ff == ST_PTR1 && mem_ack_i && is_long(req_ff.mode)
    |=> state_ff == ST_PTR2 && mem_rd_o &&
        mem_addr_o == {8'h00, $past(ptr_ff) + 8'h01};
  endproperty
  a_long_ptr_word: assert property (p_long_ptr_word) // (RL13)
    else $error("long pointer second byte not fetched");
  property p_set_mask;
    (s_inh_start and req_i.set_irq_mask_op) |=> irq_level_o == 2'h3;
  endproperty
  a_set_mask: assert property (p_set_mask) // (RL16)
    else $error("set-mask op did not reach level 3");
  property p_clr_mask;
    (s_inh_start and (!req_i.set_irq_mask_op && req_i.clear_irq_mask_op))
    |=> irq_level_o == 2'h0;
  endproperty
  a_clr_mask: assert property (p_clr_mask) // (RL17)
    else $error("clear-mask op did not reach level 0");
endmodule
`default_nettype wire

// file: verification/mem_model.sv
// Behavioural program and data memory answering the unit's read requests
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  wait_i,
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output logic      [7:0]  mem_rdata_o,
  output logic             mem_ack_o
);
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    cnt = 4'h0;
    mem_ack_o = 1'b0;
    mem_rdata_o = 8'h00;
  end

  // Data is only good with the ack; it toggles otherwise so stale reads show
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (!nrst_i) begin
      cnt <= 4'h0;
    end else if (mem_rd_i && !mem_ack_o) begin
      if (cnt >= wait_i) begin
        mem_ack_o <= 1'b1;
        mem_rdata_o <= mem[mem_addr_i];
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench for the operand address-mode unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                   clk_i;
  logic                   nrst_i;
  logic                   start_i;
  addr_mode_pkg::req_type req_i;
  logic [15:0]            pc_i;
  logic [7:0]             x_i;
  logic [7:0]             y_i;
  logic                   busy_o;
  logic                   mem_rd_o;
  logic [15:0]            mem_addr_o;
  logic [7:0]             mem_rdata;
  logic                   mem_ack;
  logic                   done_o;
  addr_mode_pkg::res_type res_o;
  logic [1:0]             irq_level_o;
  logic [3:0]             mem_wait;
  int                     errors;
  int                     total_checks;
  int                     rd_cnt;

  addr_mode_unit dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i),
    .req_i(req_i), .pc_i(pc_i), .x_i(x_i), .y_i(y_i), .busy_o(busy_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata),
    .mem_ack_i(mem_ack), .done_o(done_o), .res_o(res_o),
    .irq_level_o(irq_level_o));

  mem_model mem_u (.clk_i(clk_i), .nrst_i(nrst_i), .wait_i(mem_wait),
    .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata),
    .mem_ack_o(mem_ack));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (mem_rd_o === 1'b1 && mem_ack === 1'b1) begin
      rd_cnt++;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic poke(input logic [15:0] a, input logic [7:0] v);
    mem_u.mem[a] = v;
  endtask

  // Issues one request and judges the result; irq holds {set, clear}
  task automatic run_op(input addr_mode_pkg::mode_type m, input logic uy,
      input logic rw, input logic [1:0] irq, input logic [15:0] pc,
      input logic [7:0] xv, input logic [7:0] yv, input logic [15:0] ea,
      input logic [1:0] len, input logic he, input logic rf, input int nrd);
    int i;
    @(negedge clk_i);
    req_i.mode = m;
    req_i.use_y = uy;
    req_i.rmw = rw;
    req_i.set_irq_mask_op = irq[1];
    req_i.clear_irq_mask_op = irq[0];
    pc_i = pc;
    x_i = xv;
    y_i = yv;
    start_i = 1'b1;
    rd_cnt = 0;
    @(negedge clk_i);
    start_i = 1'b0;
    for (i = 0; i < 200 && done_o !== 1'b1; i++) begin
      @(negedge clk_i);
    end
    if (i == 200) begin
      errors++;
      $display("CHECK FAILED at %0t got %0h expected %0h", $time, 0, 1);
      tally_and_finish();
    end
    check(32'(res_o.refused), 32'(rf));
    check(rd_cnt, nrd);
    if (!rf) begin
      check(32'(res_o.has_ea), 32'(he));
      check(32'(res_o.length), 32'(len));
    end
    if (he) begin
      check(32'(res_o.ea), 32'(ea));
    end
  endtask

  task automatic t_inherent();
    check(32'(irq_level_o), 32'h3);
    run_op(addr_mode_pkg::MODE_INH, 0, 0, 2'h1, 16'h0100, 0, 0, 0, 1, 0, 0, 0);
    check(32'(irq_level_o), 32'h0);
    run_op(addr_mode_pkg::MODE_INH, 0, 0, 2'h2, 16'h0101, 0, 0, 0, 1, 0, 0, 0);
    check(32'(irq_level_o), 32'h3);
    run_op(addr_mode_pkg::MODE_INH, 0, 0, 2'h1, 16'h0102, 0, 0, 0, 1, 0, 0, 0);
    run_op(addr_mode_pkg::MODE_INH, 0, 0, 2'h3, 16'h0103, 0, 0, 0, 1, 0, 0, 0);
    check(32'(irq_level_o), 32'h3);
  endtask

  task automatic t_immediate();
    poke(16'h1235, 8'h55);
    run_op(addr_mode_pkg::MODE_IMM, 0, 0, 0, 16'h1234, 0, 0, 0, 2, 0, 0, 1);
    check(32'(res_o.operand), 32'h55);
  endtask

  task automatic t_direct();
    mem_wait = 4'h3;
    poke(16'h2001, 8'hAB);
    run_op(addr_mode_pkg::MODE_DIR_S, 0, 0, 0, 16'h2000, 0, 0, 16'h00AB, 2, 1, 0, 1);
    poke(16'h2001, 8'h12);
    poke(16'h2002, 8'h34);
    run_op(addr_mode_pkg::MODE_DIR_L, 0, 0, 0, 16'h2000, 0, 0, 16'h1234, 3, 1, 0, 2);
    mem_wait = 4'h0;
  endtask

  task automatic t_indexed();
    run_op(addr_mode_pkg::MODE_IDX_0, 0, 0, 0, 16'h3000, 8'hFE, 0, 16'h00FE, 1, 1, 0, 0);
    poke(16'h3001, 8'hFF);
    run_op(addr_mode_pkg::MODE_IDX_S, 0, 0, 0, 16'h3000, 8'hFF, 0, 16'h01FE, 2, 1, 0, 1);
    run_op(addr_mode_pkg::MODE_IDX_S, 1, 0, 0, 16'h3000, 8'hFF, 8'h02, 16'h0101, 2, 1, 0, 1);
    poke(16'h3002, 8'hF8);
    run_op(addr_mode_pkg::MODE_IDX_L, 1, 0, 0, 16'h3000, 0, 8'h10, 16'h0008, 3, 1, 0, 2);
  endtask

  task automatic t_indirect();
    poke(16'h4001, 8'h40);
    poke(16'h0040, 8'h99);
    run_op(addr_mode_pkg::MODE_IND_S, 0, 0, 0, 16'h4000, 0, 0, 16'h0099, 2, 1, 0, 2);
    mem_wait = 4'h2;
    poke(16'h4001, 8'hFF);
    poke(16'h00FF, 8'hAB);
    poke(16'h0000, 8'hCD);
    run_op(addr_mode_pkg::MODE_IND_L, 0, 0, 0, 16'h4000, 0, 0, 16'hABCD, 2, 1, 0, 3);
    mem_wait = 4'h0;
  endtask

  task automatic t_ind_indexed();
    poke(16'h5001, 8'h40);
    poke(16'h0040, 8'hFF);
    run_op(addr_mode_pkg::MODE_IIX_S, 0, 0, 0, 16'h5000, 8'h03, 0, 16'h0102, 2, 1, 0, 2);
    poke(16'h5001, 8'h30);
    poke(16'h0030, 8'h20);
    poke(16'h0031, 8'h00);
    run_op(addr_mode_pkg::MODE_IIX_L, 1, 0, 0, 16'h5000, 8'h77, 8'h05, 16'h2005, 2, 1, 0, 3);
  endtask

  task automatic t_rmw();
    addr_mode_pkg::mode_type lm [4];
    lm = '{addr_mode_pkg::MODE_DIR_L, addr_mode_pkg::MODE_IDX_L,
           addr_mode_pkg::MODE_IND_L, addr_mode_pkg::MODE_IIX_L};
    foreach (lm[k]) begin
      run_op(lm[k], 0, 1, 0, 16'h6000, 8'h01, 0, 0, 0, 0, 1, 0);
    end
    poke(16'h6001, 8'h3C);
    run_op(addr_mode_pkg::MODE_DIR_S, 0, 1, 0, 16'h6000, 0, 0, 16'h003C, 2, 1, 0, 1);
  endtask

  task automatic t_relative();
    poke(16'h1001, 8'h80);
    run_op(addr_mode_pkg::MODE_REL_D, 0, 0, 0, 16'h1000, 0, 0, 16'h0F82, 2, 1, 0, 1);
    poke(16'h1001, 8'h20);
    poke(16'h0020, 8'h7F);
    run_op(addr_mode_pkg::MODE_REL_I, 0, 0, 0, 16'h1000, 0, 0, 16'h1081, 2, 1, 0, 2);
  endtask

  initial begin
    errors = 0;
    total_checks = 0;
    rd_cnt = 0;
    nrst_i = 1'b0;
    start_i = 1'b0;
    req_i = '0;
    pc_i = 16'h0000;
    x_i = 8'h00;
    y_i = 8'h00;
    mem_wait = 4'h0;
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    check(32'(busy_o), 32'h0);
    t_inherent();
    t_immediate();
    t_direct();
    t_indexed();
    t_indirect();
    t_ind_indexed();
    t_rmw();
    t_relative();
    tally_and_finish();
  end
endmodule
`default_nettype wire
